// ===== verilog/vid_reference_decoder.sv
// vid reference decoder: turns management-bus settings into dac reference values
// assumes commands arrive already parsed as one code plus one data word per cycle
//
// What this block does
// - vid zero turns output off; else code 1 gives 0.250 V or 0.500 V, plus one step per code above
// - in 5 mV mode margin offset code n shifts output by 5n mV, -640..635
// - in 10 mV mode margin offset code n shifts output by 10n mV, -1280..1270
// - strap level sampled after reset picks 5 mV or 10 mV tables
// - droop current joins feedback by default; host may disconnect it
// - five-bit signed field sets calibration current into feedback resistor
// - with droop, second five-bit field adds current on monitor pin and droop path
module vid_reference_decoder
  import vid_ref_pkg::*;
(
  input wire logic clock,
  input wire logic srst,
  input wire logic clk_en,
  input wire logic mode_address_select_pin,
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] rsp_data,
  output logic rsp_valid,
  output logic ref_on,
  output logic [11:0] ref_mv,
  output logic [11:0] margin_mv,
  output logic droop_connect,
  output logic [4:0] cal_current_code,
  output logic [4:0] current_monitor_pin_current_code,
  output logic step_resolution_select
);
  dec_state_t st_r;
  dec_state_t st_nxt;
  logic [11:0] step_mv;
  logic [11:0] vid_ext;
  logic [11:0] margin_ext;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    st_nxt = st_r;
    // strap caught on the first enabled edge after release, never under reset
    if (!st_r.strap_done) begin
      st_nxt.strap_done = 1'b1;
      st_nxt.mode_10mv = mode_address_select_pin;
    end
    st_nxt.rvalid = 1'b0;
    if (cmd_valid && cmd_write) begin
      if (cmd_code == `CMD_MAX_OUTPUT_VOLTAGE_LIMIT) begin
        st_nxt.max_output_voltage_limit = cmd_wdata;
      end else if (cmd_code == `CMD_DROOP_OFFSET_CALIBRATION) begin
        st_nxt.droop_cal = cmd_wdata;
      end else if (cmd_code == `CMD_BOOT_VOLTAGE_SETTING) begin
        st_nxt.boot = cmd_wdata;
      end else if (cmd_code == `CMD_DROOP_CONTROL) begin
        st_nxt.droop_en = cmd_wdata[`DROOP_EN_BIT];
      end else if (cmd_code == `CMD_VID_SETTING) begin
        st_nxt.vid = cmd_wdata[7:0];
      end else if (cmd_code == `CMD_MARGIN_OFFSET) begin
        st_nxt.margin = cmd_wdata[7:0];
      end
    end else if (cmd_valid) begin
      st_nxt.rvalid = 1'b1;
      if (cmd_code == `CMD_MAX_OUTPUT_VOLTAGE_LIMIT) begin
        st_nxt.rdata = st_r.max_output_voltage_limit;
      end else if (cmd_code == `CMD_DROOP_OFFSET_CALIBRATION) begin
        st_nxt.rdata = st_r.droop_cal;
      end else if (cmd_code == `CMD_BOOT_VOLTAGE_SETTING) begin
        st_nxt.rdata = st_r.boot;
      end else if (cmd_code == `CMD_DROOP_CONTROL) begin
        st_nxt.rdata = {15'h0000, st_r.droop_en};
      end else if (cmd_code == `CMD_VID_SETTING) begin
        st_nxt.rdata = {8'h00, st_r.vid};
      end else if (cmd_code == `CMD_MARGIN_OFFSET) begin
        st_nxt.rdata = {8'h00, st_r.margin};
      end else if (cmd_code == `CMD_DECODER_STATUS) begin
        st_nxt.rdata = {14'h0000, st_r.ref_on, st_r.mode_10mv};
      end else begin
        // unmapped codes read back zero
        st_nxt.rdata = 16'h0000;
      end
    end
    // outputs follow settings one cycle later; the dac sees a settled word
    st_nxt.ref_on = (st_r.vid != 8'h00);
    st_nxt.ref_mv = (st_r.vid == 8'h00) ? 12'h000 : 12'((vid_ext + `VID_BASE_STEPS) * step_mv);
    st_nxt.margin_mv = 12'($signed(margin_ext) * $signed(step_mv));
    st_nxt.droop_connect = st_r.droop_en;
    st_nxt.cal_code = st_r.droop_cal[`CAL_FIELD_HI:`CAL_FIELD_LO];
    // monitor-pin injection only makes sense with droop in the loop
    st_nxt.current_monitor_pin_code = st_r.droop_en ? st_r.droop_cal[`CURRENT_MONITOR_PIN_FIELD_HI:`CURRENT_MONITOR_PIN_FIELD_LO] : 5'h00;
  end

  assign step_mv = st_r.mode_10mv ? `STEP_COARSE_MV : `STEP_FINE_MV;
  assign vid_ext = {4'h0, st_r.vid};
  assign margin_ext = {{4{st_r.margin[7]}}, st_r.margin};

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      st_r <= '0;
      st_r.droop_en <= `RST_DROOP_EN;
      st_r.droop_connect <= `RST_DROOP_EN;
      st_r.max_output_voltage_limit <= `RST_MAX_OUTPUT_VOLTAGE;
      st_r.droop_cal <= `RST_DROOP_CAL;
      st_r.boot <= `RST_BOOT_VOLTAGE;
      st_r.vid <= `RST_VID;
      st_r.margin <= `RST_MARGIN;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign rsp_data = st_r.rdata;
  assign rsp_valid = st_r.rvalid;
  assign ref_on = st_r.ref_on;
  assign ref_mv = st_r.ref_mv;
  assign margin_mv = st_r.margin_mv;
  assign droop_connect = st_r.droop_connect;
  assign cal_current_code = st_r.cal_code;
  assign current_monitor_pin_current_code = st_r.current_monitor_pin_code;
  assign step_resolution_select = st_r.mode_10mv;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  a_vid_off_zero: assert property (
    clk_en && st_r.vid == 8'h00 |=> !ref_on && ref_mv == 12'h000)
    else $error("zero vid did not turn reference off");
  a_vid_fine_value: assert property (
    clk_en && st_r.vid != 8'h00 && !st_r.mode_10mv
      |=> ref_mv == 12'(({4'h0, $past(st_r.vid)} + 12'd49) * 12'd5))
    else $error("fine mode reference value wrong");
  a_vid_coarse_value: assert property (
    clk_en && st_r.vid != 8'h00 && st_r.mode_10mv
      |=> ref_mv == 12'(({4'h0, $past(st_r.vid)} + 12'd49) * 12'd10))
    else $error("coarse mode reference value wrong");
  a_margin_fine_step: assert property (
    clk_en && !st_r.mode_10mv && st_r.margin == 8'h80 |=> margin_mv == 12'hd80)
    else $error("fine margin minimum not -640 mV");
  a_margin_coarse_step: assert property (
    clk_en && st_r.mode_10mv && st_r.margin == 8'h7f |=> margin_mv == 12'h4f6)
    else $error("coarse margin maximum not 1270 mV");
  a_strap_mode_hold: assert property (
    st_r.strap_done |=> $stable(step_resolution_select))
    else $error("step mode changed after strap capture");
  a_droop_disconnect: assert property (
    clk_en && cmd_valid && cmd_write && cmd_code == 8'hd0 && !cmd_wdata[0]
      |=> ##1 (!droop_connect || !clk_en))
    else $error("droop not disconnected");
  a_cal_field_map: assert property (
    clk_en |=> cal_current_code == $past(st_r.droop_cal[9:5]))
    else $error("calibration field not forwarded");
  a_current_monitor_pin_gated: assert property (
    !droop_connect |-> current_monitor_pin_current_code == 5'h00)
    else $error("monitor current injected without droop");
  a_margin_sign: assert property (
    clk_en && st_r.margin[7] |=> margin_mv[11])
    else $error("negative margin code not negative");
  a_read_answer: assert property (
    clk_en && cmd_valid && !cmd_write |=> rsp_valid)
    else $error("read not answered next cycle");

  a_write_silent: assert property (
    clk_en && cmd_valid && cmd_write |=> !rsp_valid)
    else $error("write produced a read answer");

  a_status_word: assert property (
    clk_en && cmd_valid && !cmd_write && cmd_code == `CMD_DECODER_STATUS
      |=> rsp_data == {14'h0000, $past(ref_on), $past(step_resolution_select)})
    else $error("status word does not match state");

  // ----------------------------------------
  // reference enable, margin zero and margin end points
  // ----------------------------------------
  a_ref_on_follow: assert property (
    clk_en && st_r.vid != 8'h00 |=> ref_on)
    else $error("nonzero vid left reference off");

  a_margin_zero: assert property (
    clk_en && st_r.margin == 8'h00 |=> margin_mv == 12'h000)
    else $error("zero margin code not zero offset");

  a_margin_fine_top: assert property (
    clk_en && !st_r.mode_10mv && st_r.margin == 8'h7f |=> margin_mv == 12'h27b)
    else $error("fine margin maximum not 635 mV");

  a_margin_coarse_low: assert property (
    clk_en && st_r.mode_10mv && st_r.margin == 8'h80 |=> margin_mv == 12'hb00)
    else $error("coarse margin minimum not -1280 mV");

  // ----------------------------------------
  // droop and monitor injection
  // ----------------------------------------
  a_droop_default: assert property (
    $fell(srst) |-> droop_connect)
    else $error("droop not connected after reset");

  a_droop_reconnect: assert property (
    clk_en && cmd_valid && cmd_write && cmd_code == `CMD_DROOP_CONTROL && cmd_wdata[0]
      |=> ##1 (droop_connect || !clk_en))
    else $error("droop not reconnected");

  a_current_monitor_pin_follow: assert property (
    clk_en && st_r.droop_en |=> current_monitor_pin_current_code == $past(st_r.droop_cal[4:0]))
    else $error("monitor field not forwarded with droop on");

  // ----------------------------------------
  // cover points
  // ----------------------------------------
  c_coarse_on: cover property (clk_en && st_r.mode_10mv ##1 ref_on);
  c_fine_on: cover property (clk_en && !st_r.mode_10mv ##1 ref_on);
  c_neg_margin: cover property (margin_mv[11]);
  c_droop_off: cover property (!droop_connect);
  c_status_read: cover property (clk_en && cmd_valid && !cmd_write && cmd_code == 8'hd3);
endmodule

// ===== verilog/vid_ref_cfg.svh
// constants for the vid reference decoder: offsets, fields, reset values
// assumes one 8-bit command code space addressed by the management bus front end
`ifndef VID_REF_CFG_SVH
`define VID_REF_CFG_SVH
// ----------------------------------------
// command codes
// ----------------------------------------
`define CMD_MAX_OUTPUT_VOLTAGE_LIMIT 8'h24
`define CMD_DROOP_OFFSET_CALIBRATION 8'he4
`define CMD_BOOT_VOLTAGE_SETTING 8'he6
`define CMD_DROOP_CONTROL 8'hd0
`define CMD_VID_SETTING 8'hd1
`define CMD_MARGIN_OFFSET 8'hd2
`define CMD_DECODER_STATUS 8'hd3
// ----------------------------------------
// fields
// ----------------------------------------
`define CAL_FIELD_HI 9
`define CAL_FIELD_LO 5
`define CURRENT_MONITOR_PIN_FIELD_HI 4
`define CURRENT_MONITOR_PIN_FIELD_LO 0
`define DROOP_EN_BIT 0
`define STATUS_MODE_BIT 0
`define STATUS_ON_BIT 1
// ----------------------------------------
// reset values
// ----------------------------------------
`define RST_MAX_OUTPUT_VOLTAGE 16'h00ff
`define RST_DROOP_CAL 16'h0000
`define RST_BOOT_VOLTAGE 16'h0000
`define RST_DROOP_EN 1'b1
`define RST_VID 8'h00
`define RST_MARGIN 8'h00
// ----------------------------------------
// decode figures: step sizes in millivolts, base offset in steps
// ----------------------------------------
`define STEP_FINE_MV 12'h005
`define STEP_COARSE_MV 12'h00a
`define VID_BASE_STEPS 12'h031
`endif

// ===== verilog/vid_ref_pkg.sv
// types for the vid reference decoder
// assumes vid_ref_cfg.svh is on the include path
package vid_ref_pkg;
  `include "vid_ref_cfg.svh"
  typedef struct packed {
    logic strap_done;
    logic mode_10mv;
    logic droop_en;
    logic [7:0] vid;
    logic [7:0] margin;
    logic [15:0] max_output_voltage_limit;
    logic [15:0] droop_cal;
    logic [15:0] boot;
    logic ref_on;
    logic [11:0] ref_mv;
    logic [11:0] margin_mv;
    logic droop_connect;
    logic [4:0] cal_code;
    logic [4:0] current_monitor_pin_code;
    logic [15:0] rdata;
    logic rvalid;
  } dec_state_t;
endpackage

// ===== testbench/host_model.sv
// host model: issues management-bus commands to the decoder, one at a time
// assumes the decoder takes a command on a rising edge with cmd_valid high
`include "vid_ref_cfg.svh"
module host_model (
  input wire logic clock,
  input wire logic [15:0] rsp_data,
  input wire logic rsp_valid,
  output logic cmd_valid,
  output logic cmd_write,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid = 1'b0;
    cmd_write = 1'b0;
    cmd_code = 8'h00;
    cmd_wdata = 16'h0000;
  end
  task automatic issue(input logic wr, input logic [7:0] code, input logic [15:0] data);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_write <= wr;
    cmd_code <= code;
    cmd_wdata <= data;
    @(posedge clock);
    cmd_valid <= 1'b0;
    // idle lines never keep the old value, so a stale sample cannot pass
    cmd_write <= ~wr;
    cmd_code <= ~code;
    cmd_wdata <= ~data;
  endtask
  task automatic rd(input logic [7:0] code, output logic [15:0] data);
    issue(1'b0, code, 16'h0000);
    #1;
    data = (rsp_valid === 1'b1) ? rsp_data : 16'hxxxx;
  endtask
  // limits chosen to suit the step mode in use
  task automatic configure(input logic m);
    issue(1'b1, `CMD_MAX_OUTPUT_VOLTAGE_LIMIT, m ? 16'h0130 : 16'h0098);
    issue(1'b1, `CMD_BOOT_VOLTAGE_SETTING, m ? 16'h00fa : 16'h007e);
  endtask
endmodule

// ===== testbench/tb_top.sv
// testbench for the vid reference decoder
// assumes host_model drives the command port; clk_en high except in the freeze scenario
`include "vid_ref_cfg.svh"
module tb_top;
  import vid_ref_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, srst = 1'b1, strap = 1'b0, clk_en = 1'b1;
  logic cmd_valid, cmd_write, rsp_valid, ref_on, droop_connect, step_resolution_select;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rsp_data, rd_v;
  logic [11:0] ref_mv, margin_mv;
  logic [4:0] cal_current_code, current_monitor_pin_current_code;
  int err_count = 0, comparisons = 0, cycles = 0;
  logic [7:0] codes [4] = '{8'h01, 8'h3a, 8'hff, 8'h00};
  logic [7:0] mcodes [4] = '{8'h7f, 8'h80, 8'h01, 8'hff};
  always #20 clock = ~clock;
  host_model host_model_inst (.clock(clock), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
  vid_reference_decoder vid_reference_decoder_inst (.clock(clock), .srst(srst), .clk_en(clk_en),
    .mode_address_select_pin(strap), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_data(rsp_data), .rsp_valid(rsp_valid),
    .ref_on(ref_on), .ref_mv(ref_mv), .margin_mv(margin_mv), .droop_connect(droop_connect),
    .cal_current_code(cal_current_code), .current_monitor_pin_current_code(current_monitor_pin_current_code),
    .step_resolution_select(step_resolution_select));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic print_verdict;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      print_verdict;
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr_settle(input logic [7:0] code, input logic [15:0] data);
    host_model_inst.issue(1'b1, code, data);
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic do_reset(input logic s);
    @(posedge clock);
    srst <= 1'b1;
    strap <= s;
    repeat (6) @(posedge clock);
    srst <= 1'b0;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    host_model_inst.rd(`CMD_MAX_OUTPUT_VOLTAGE_LIMIT, rd_v);
    chk(rd_v, 16'h00ff, "max reset");
    chk({15'h0, droop_connect}, 16'h0001, "droop default");
    host_model_inst.configure(1'b0);
    host_model_inst.rd(`CMD_BOOT_VOLTAGE_SETTING, rd_v);
    chk(rd_v, 16'h007e, "boot");
    host_model_inst.rd(8'h55, rd_v);
    chk(rd_v, 16'h0000, "unmapped");
  endtask
  task automatic t_vid(input int step);
    chk({15'h0, step_resolution_select}, {15'h0, step == 10}, "mode");
    host_model_inst.rd(`CMD_DECODER_STATUS, rd_v);
    chk(rd_v, {15'h0, step == 10}, "status");
    foreach (codes[i]) begin
      wr_settle(`CMD_VID_SETTING, {8'h00, codes[i]});
      chk({4'h0, ref_mv}, codes[i] == 0 ? 16'h0 : 16'(step * (codes[i] + 49)), "ref");
      chk({15'h0, ref_on}, {15'h0, codes[i] != 0}, "on");
    end
  endtask
  // boundary codes 7f and 80 hit both ends of the margin range
  task automatic t_margin(input int step);
    foreach (mcodes[i]) begin
      wr_settle(`CMD_MARGIN_OFFSET, {8'h00, mcodes[i]});
      chk({4'h0, margin_mv}, {4'h0, 12'(step * $signed(mcodes[i]))}, "margin");
    end
  endtask
  task automatic t_droop;
    wr_settle(`CMD_DROOP_OFFSET_CALIBRATION, 16'h020f);
    chk({11'h0, cal_current_code}, 16'h0010, "cal");
    chk({11'h0, current_monitor_pin_current_code}, 16'h000f, "current_monitor_pin on");
    wr_settle(`CMD_DROOP_CONTROL, 16'h0000);
    chk({15'h0, droop_connect}, 16'h0000, "droop off");
    chk({11'h0, current_monitor_pin_current_code}, 16'h0000, "current_monitor_pin off");
    wr_settle(`CMD_DROOP_CONTROL, 16'h0001);
    chk({15'h0, droop_connect}, 16'h0001, "droop back on");
    chk({11'h0, current_monitor_pin_current_code}, 16'h000f, "current_monitor_pin back");
  endtask
  // a command offered while the clock enable is low must not be taken
  task automatic t_freeze;
    @(posedge clock);
    clk_en <= 1'b0;
    wr_settle(`CMD_VID_SETTING, 16'h0001);
    chk({4'h0, ref_mv}, 16'h0000, "frozen ref");
    @(posedge clock);
    clk_en <= 1'b1;
    host_model_inst.rd(`CMD_VID_SETTING, rd_v);
    chk(rd_v, 16'h0000, "frozen vid");
  endtask
  initial begin
    do_reset(1'b0);
    t_regs;
    t_vid(5);
    t_margin(5);
    t_droop;
    t_freeze;
    do_reset(1'b1);
    host_model_inst.configure(1'b1);
    t_vid(10);
    t_margin(10);
    print_verdict;
  end
endmodule
